// File: inc/uefc_pkg.sv
/*
 * Constants for the enhanced feature control block: register offsets,
 * protected bit masks, status bit positions, reset values and the
 * flow character matcher states.
 * Assumes an 8-bit register port with one byte per address.
 */
package uefc_pkg;

   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam logic [7:0] ADDR_ENH_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_INT_ENABLE  = 8'h01;
   localparam logic [7:0] ADDR_INT_STATUS  = 8'h02;
   localparam logic [7:0] ADDR_FIFO_CTRL   = 8'h03;
   localparam logic [7:0] ADDR_MODEM_CTRL  = 8'h04;
   localparam logic [7:0] ADDR_RESUME_1    = 8'h05;
   localparam logic [7:0] ADDR_RESUME_2    = 8'h06;
   localparam logic [7:0] ADDR_STOP_1      = 8'h07;
   localparam logic [7:0] ADDR_STOP_2      = 8'h08;
   localparam logic [7:0] ADDR_FLOW_HIGH   = 8'h09;
   localparam logic [7:0] ADDR_FLOW_LOW    = 8'h0a;
   localparam logic [7:0] ADDR_INT_MASK    = 8'h0b;
   localparam logic [7:0] ADDR_LINE_STATE  = 8'h0c;

   // ****************************************************************
   // Field positions and masks
   // ****************************************************************
   localparam int         ENH_AUTO_RTS     = 6;
   localparam int         ENH_SPECIAL      = 5;
   localparam int         ENH_UNLOCK       = 4;
   localparam int         MODEM_RTS        = 1;
   localparam int         STAT_STOP_SEEN   = 0;
   localparam int         STAT_RESUME_SEEN = 1;
   localparam int         STAT_SPECIAL     = 4;
   localparam int         STAT_RTS_RAISED  = 5;
   localparam logic [7:0] PROT_INT_ENABLE  = 8'hf0;
   localparam logic [7:0] PROT_INT_STATUS  = 8'h30;
   localparam logic [7:0] PROT_FIFO_CTRL   = 8'h30;
   localparam logic [7:0] PROT_MODEM_CTRL  = 8'he0;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [7:0] RST_BYTE         = 8'h00;

   // Flow character matcher: waiting, or first half of a pair seen
   typedef enum logic [1:0] {UEFC_IDLE, UEFC_GOT_RESUME, UEFC_GOT_STOP} uefc_state_t;

endpackage : uefc_pkg

// File: core/uefc_core.sv
/*
 * Enhanced feature control for a UART: register file, write protection
 * of the enhanced bits, special character detection, software flow
 * character matching, automatic request-to-send and the interrupt line.
 * Assumes received characters arrive as one-cycle strobes and that the
 * receive FIFO level is supplied synchronous to clk.
 */
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module uefc_core
   import uefc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output var  logic [7:0] rdata,
   input  wire logic       rx_valid,
   input  wire logic [7:0] rx_data,
   input  wire logic [7:0] rx_level,
   output var  logic       rx_fifo_wr,
   output var  logic [7:0] rx_fifo_data,
   output var  logic       rts_level,
   output var  logic       resume_seen,
   output var  logic       stop_seen,
   output var  logic       irq,
   output var  logic [7:0] enhanced_feature_control,
   output var  logic [7:0] interrupt_enable,
   output var  logic [7:0] fifo_control,
   output var  logic [7:0] modem_control
);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Keeps frozen bits, takes the rest from the write data
   function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                             input logic [7:0] new_v,
                                             input logic [7:0] open_m);
      merge_byte = (old_v & ~open_m) | (new_v & open_m);
   endfunction : merge_byte

   // Trigger setting zero means a level of one
   function automatic logic [7:0] trig_level(input logic [7:0] setting);
      trig_level = (setting == RST_BYTE) ? 8'h01 : setting;
   endfunction : trig_level

   // Plain bitwise compare, bit 0 against the first received bit
   function automatic logic char_eq(input logic [7:0] a, input logic [7:0] b);
      char_eq = (a == b);
   endfunction : char_eq

   // ****************************************************************
   // Register file
   // ****************************************************************
   logic [7:0] interrupt_status;
   logic [7:0] first_resume_character;
   logic [7:0] second_resume_character;
   logic [7:0] first_stop_character;
   logic [7:0] second_stop_character;
   logic [7:0] flow_high;
   logic [7:0] flow_low;
   logic [7:0] interrupt_mask;
   logic [7:0] next_efc, next_ier, next_isr, next_fcr, next_mcr;
   logic [7:0] next_res1, next_res2, next_stop1, next_stop2;
   logic [7:0] next_high, next_low, next_mask, next_rdata;
   logic [7:0] set_events, clr_bits;
   logic [7:0] open_ier, open_isr, open_fcr, open_mcr;
   logic       unlocked, special_hit, rts_rise;
   logic       next_resume, next_stop, next_rts;
   uefc_state_t state, next_state;

   // Protection masks follow the unlock bit of the current register
   always_comb begin
      unlocked = enhanced_feature_control[ENH_UNLOCK];
      open_ier = unlocked ? 8'hff : ~PROT_INT_ENABLE;
      open_isr = unlocked ? 8'hff : ~PROT_INT_STATUS;
      open_fcr = unlocked ? 8'hff : ~PROT_FIFO_CTRL;
      open_mcr = unlocked ? 8'hff : ~PROT_MODEM_CTRL;
   end

   // Special detection runs only while bit 5 is set
   always_comb begin
      special_hit = rx_valid && enhanced_feature_control[ENH_SPECIAL]
                    && char_eq(rx_data, second_stop_character);
   end

   // Hardware events; a set in the clearing cycle survives the clear
   always_comb begin
      set_events                  = 8'h00;
      set_events[STAT_SPECIAL]    = special_hit;
      set_events[STAT_STOP_SEEN]  = next_stop;
      set_events[STAT_RESUME_SEEN] = next_resume;
      set_events[STAT_RTS_RAISED] = rts_rise;
      clr_bits = (wr && addr == ADDR_INT_STATUS) ? (wdata & open_isr) : 8'h00;
      next_isr = (interrupt_status & ~clr_bits) | set_events;
   end

   // Software writes and read decode
   always_comb begin
      next_efc   = enhanced_feature_control;
      next_ier   = interrupt_enable;
      next_fcr   = fifo_control;
      next_mcr   = modem_control;
      next_res1  = first_resume_character;
      next_res2  = second_resume_character;
      next_stop1 = first_stop_character;
      next_stop2 = second_stop_character;
      next_high  = flow_high;
      next_low   = flow_low;
      next_mask  = interrupt_mask;
      next_rdata = 8'h00;
      if (wr) begin
         unique case (addr)
            ADDR_ENH_CTRL:   next_efc   = wdata;
            ADDR_INT_ENABLE: next_ier   = merge_byte(interrupt_enable, wdata, open_ier);
            ADDR_FIFO_CTRL:  next_fcr   = merge_byte(fifo_control, wdata, open_fcr);
            ADDR_MODEM_CTRL: next_mcr   = merge_byte(modem_control, wdata, open_mcr);
            ADDR_RESUME_1:   next_res1  = wdata;
            ADDR_RESUME_2:   next_res2  = wdata;
            ADDR_STOP_1:     next_stop1 = wdata;
            ADDR_STOP_2:     next_stop2 = wdata;
            ADDR_FLOW_HIGH:  next_high  = wdata;
            ADDR_FLOW_LOW:   next_low   = wdata;
            ADDR_INT_MASK:   next_mask  = wdata;
            default:         next_mask  = interrupt_mask;
         endcase
      end
      if (rd) begin
         unique case (addr)
            ADDR_ENH_CTRL:   next_rdata = enhanced_feature_control;
            ADDR_INT_ENABLE: next_rdata = interrupt_enable;
            ADDR_INT_STATUS: next_rdata = interrupt_status;
            ADDR_FIFO_CTRL:  next_rdata = fifo_control;
            ADDR_MODEM_CTRL: next_rdata = modem_control;
            ADDR_RESUME_1:   next_rdata = first_resume_character;
            ADDR_RESUME_2:   next_rdata = second_resume_character;
            ADDR_STOP_1:     next_rdata = first_stop_character;
            ADDR_STOP_2:     next_rdata = second_stop_character;
            ADDR_FLOW_HIGH:  next_rdata = flow_high;
            ADDR_FLOW_LOW:   next_rdata = flow_low;
            ADDR_INT_MASK:   next_rdata = interrupt_mask;
            ADDR_LINE_STATE: next_rdata = {7'h00, rts_level};
            default:         next_rdata = 8'h00; // Unmapped reads give zero
         endcase
      end
   end

   // All registers clear on reset, leaving every enhanced feature off
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         enhanced_feature_control <= RST_BYTE;
         interrupt_enable         <= RST_BYTE;
         interrupt_status         <= RST_BYTE;
         fifo_control             <= RST_BYTE;
         modem_control            <= RST_BYTE;
         first_resume_character   <= RST_BYTE;
         second_resume_character  <= RST_BYTE;
         first_stop_character     <= RST_BYTE;
         second_stop_character    <= RST_BYTE;
         flow_high                <= RST_BYTE;
         flow_low                 <= RST_BYTE;
         interrupt_mask           <= RST_BYTE;
         rdata                    <= RST_BYTE;
         irq                      <= 1'b0;
      end else begin
         enhanced_feature_control <= next_efc;
         interrupt_enable         <= next_ier;
         interrupt_status         <= next_isr;
         fifo_control             <= next_fcr;
         modem_control            <= next_mcr;
         first_resume_character   <= next_res1;
         second_resume_character  <= next_res2;
         first_stop_character     <= next_stop1;
         second_stop_character    <= next_stop2;
         flow_high                <= next_high;
         flow_low                 <= next_low;
         interrupt_mask           <= next_mask;
         rdata                    <= next_rdata;
         irq                      <= |(next_isr & next_mask);
      end
   end

   // ****************************************************************
   // Flow character matcher
   // ****************************************************************
   // Receive select 11 with transmit select 11 needs both characters of a
   // pair back to back; the senders keep these codes out of payload.
   logic [1:0] tx_sel, rx_sel;
   logic       dbl, either, on1, on2, off1, off2;

   always_comb begin
      tx_sel      = enhanced_feature_control[3:2];
      rx_sel      = enhanced_feature_control[1:0];
      dbl         = (rx_sel == 2'b11) && (tx_sel == 2'b11);
      either      = (rx_sel == 2'b11) && (tx_sel != 2'b11);
      on1         = char_eq(rx_data, first_resume_character);
      on2         = char_eq(rx_data, second_resume_character);
      off1        = char_eq(rx_data, first_stop_character);
      off2        = char_eq(rx_data, second_stop_character);
      next_state  = state;
      next_resume = 1'b0;
      next_stop   = 1'b0;
      if (rx_valid) begin
         if (dbl) begin
            unique case (state)
               UEFC_GOT_RESUME: next_resume = on2;
               UEFC_GOT_STOP:   next_stop   = off2;
               UEFC_IDLE:       next_resume = 1'b0;
            endcase
            if (next_resume || next_stop) begin
               next_state = UEFC_IDLE;
            end else if (on1) begin
               next_state = UEFC_GOT_RESUME;
            end else if (off1) begin
               next_state = UEFC_GOT_STOP;
            end else begin
               next_state = UEFC_IDLE;
            end
         end else begin
            next_state  = UEFC_IDLE;
            next_resume = (rx_sel == 2'b10 && on1) || (rx_sel == 2'b01 && on2)
                          || (either && (on1 || on2));
            next_stop   = (rx_sel == 2'b10 && off1) || (rx_sel == 2'b01 && off2)
                          || (either && (off1 || off2));
         end
      end
   end

   // ****************************************************************
   // Request-to-send and receive pass-through
   // ****************************************************************
   // Hysteresis between the two levels avoids chatter near one threshold
   always_comb begin
      if (enhanced_feature_control[ENH_AUTO_RTS]) begin
         if (rx_level >= trig_level(flow_high)) begin
            next_rts = 1'b1;
         end else if (rx_level < trig_level(flow_low)) begin
            next_rts = 1'b0;
         end else begin
            next_rts = rts_level;
         end
      end else begin
         next_rts = modem_control[MODEM_RTS];
      end
      rts_rise = enhanced_feature_control[ENH_AUTO_RTS] && next_rts && !rts_level;
   end

   // Matched characters still go into the FIFO, one cycle behind
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state        <= UEFC_IDLE;
         rts_level    <= 1'b0;
         resume_seen  <= 1'b0;
         stop_seen    <= 1'b0;
         rx_fifo_wr   <= 1'b0;
         rx_fifo_data <= RST_BYTE;
      end else begin
         state        <= next_state;
         rts_level    <= next_rts;
         resume_seen  <= next_resume;
         stop_seen    <= next_stop;
         rx_fifo_wr   <= rx_valid;
         rx_fifo_data <= rx_data;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_special_flag_set: assert property (special_hit |=> interrupt_status[STAT_SPECIAL])
      else $error("special character did not set status bit 4");
   a_special_needs_en: assert property (
      (rx_valid && !enhanced_feature_control[ENH_SPECIAL] && !interrupt_status[STAT_SPECIAL])
      |=> !interrupt_status[STAT_SPECIAL])
      else $error("status bit 4 set with detection off");
   a_char_still_stored: assert property (
      rx_valid |=> rx_fifo_wr && rx_fifo_data == $past(rx_data))
      else $error("received character not passed to FIFO");
   a_auto_rts_high: assert property (
      (enhanced_feature_control[ENH_AUTO_RTS] && rx_level >= trig_level(flow_high)) |=> rts_level)
      else $error("auto request-to-send did not rise at high level");
   a_auto_rts_low: assert property (
      (enhanced_feature_control[ENH_AUTO_RTS] && rx_level < trig_level(flow_low)
       && rx_level < trig_level(flow_high)) |=> !rts_level)
      else $error("auto request-to-send did not fall below low level");
   a_manual_rts: assert property (
      !enhanced_feature_control[ENH_AUTO_RTS] |=> rts_level == $past(modem_control[MODEM_RTS]))
      else $error("request-to-send not following modem control");
   a_locked_hold: assert property (
      (wr && addr == ADDR_INT_ENABLE && !unlocked)
      |=> interrupt_enable[7:4] == $past(interrupt_enable[7:4]))
      else $error("protected enable bits changed while locked");
   a_unlocked_write: assert property (
      (wr && addr == ADDR_MODEM_CTRL && unlocked) |=> modem_control == $past(wdata))
      else $error("modem control write lost while unlocked");
   a_single_stop: assert property (
      (rx_valid && enhanced_feature_control[1:0] == 2'b10 && off1)
      |=> stop_seen ##1 interrupt_status[STAT_STOP_SEEN])
      else $error("first stop character not matched");
   a_read_back: assert property (
      (rd && addr == ADDR_ENH_CTRL) |=> rdata == $past(enhanced_feature_control))
      else $error("enhanced register read mismatch");
   a_irq_level: assert property (irq == |(interrupt_status & interrupt_mask))
      else $error("interrupt line disagrees with status and mask");

   c_special_seen: cover property (special_hit ##1 irq);
   c_pair_resume:  cover property (dbl && state == UEFC_GOT_RESUME ##1 resume_seen);
   c_rts_cycle:    cover property (rts_rise ##[1:50] !rts_level);
   c_locked_write: cover property (wr && addr == ADDR_FIFO_CTRL && !unlocked);

endmodule : uefc_core
`default_nettype wire

// File: tb/uefc_remote.sv
/*
 * Far-side model: the remote serial sender as the core sees it, one
 * received character strobe at a time, plus the receive FIFO level.
 * Assumes the bench supplies clk and calls the tasks in one process.
 */
`timescale 1ns/1ps
`default_nettype none
module uefc_remote (
   input  wire logic       clk,
   output var  logic       rx_valid,
   output var  logic [7:0] rx_data,
   output var  logic [7:0] rx_level
);
   // ****************************************************************
   // Sender
   // ****************************************************************
   // Idle lines at time zero
   initial begin
      rx_valid = 1'b0;
      rx_data  = 8'h00;
      rx_level = 8'h00;
   end

   // One strobe; the data lines flip afterwards so a stale byte is never reused
   task automatic send_char(input logic [7:0] b);
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data  <= b;
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_data  <= ~b;
   endtask : send_char

   // Fill level changes just after an edge, like a real FIFO counter
   task automatic set_level(input logic [7:0] n);
      @(posedge clk);
      rx_level <= n;
   endtask : set_level
endmodule : uefc_remote
`default_nettype wire

// File: tb/uefc_core_test.sv
/*
 * Self-checking bench for the enhanced feature control core: register
 * port tasks, received character checks and request-to-send levels.
 * Assumes the package offsets and the remote sender model.
 */
`timescale 1ns/1ps
`default_nettype none
module uefc_core_test;
   import uefc_pkg::*;
   logic       clk, rst, wr, rd, rx_valid, rx_fifo_wr, rts_level;
   logic       resume_seen, stop_seen, irq;
   logic [7:0] addr, wdata, rdata, rx_data, rx_level, rx_fifo_data;
   logic [7:0] enhanced_feature_control, interrupt_enable, fifo_control, modem_control;
   int         err_total, checks_done;
   // Protected registers and their guarded bits
   localparam logic [15:0] LOCK [3] = '{{ADDR_INT_ENABLE, PROT_INT_ENABLE},
      {ADDR_FIFO_CTRL, PROT_FIFO_CTRL}, {ADDR_MODEM_CTRL, PROT_MODEM_CTRL}};
   // Flow select, character, expected stop and resume pulses
   localparam logic [17:0] FLOW [15] = '{{8'h00, 8'h13, 2'b00},
      {8'h02, 8'h13, 2'b10}, {8'h02, 8'h11, 2'b01}, {8'h02, 8'h23, 2'b00},
      {8'h01, 8'h23, 2'b10}, {8'h01, 8'h13, 2'b00}, {8'h01, 8'h21, 2'b01},
      {8'h0b, 8'h13, 2'b10}, {8'h0b, 8'h23, 2'b10}, {8'h0b, 8'h21, 2'b01},
      {8'h0f, 8'h13, 2'b00}, {8'h0f, 8'h23, 2'b10}, {8'h0f, 8'h23, 2'b00},
      {8'h0f, 8'h11, 2'b00}, {8'h0f, 8'h21, 2'b01}};

   uefc_core uefc_core_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_level(rx_level), .rx_fifo_wr(rx_fifo_wr), .rx_fifo_data(rx_fifo_data),
      .rts_level(rts_level), .resume_seen(resume_seen), .stop_seen(stop_seen),
      .irq(irq), .enhanced_feature_control(enhanced_feature_control),
      .interrupt_enable(interrupt_enable), .fifo_control(fifo_control),
      .modem_control(modem_control));
   uefc_remote uefc_remote_inst (.clk(clk), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_level(rx_level));

   // ****************************************************************
   // Access and compare tasks
   // ****************************************************************
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t byte got %h want %h", $time, got, exp);
      end
   endtask : chk_byte

   task automatic chk_bit(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t bit got %b want %b", $time, got, exp);
      end
   endtask : chk_bit

   task automatic tick;
      @(posedge clk);
      #1;
   endtask : tick

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : wr_reg

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      chk_byte(rdata, exp);
   endtask : rd_chk

   // Every character is stored, matched or not
   task automatic rx_chk(input logic [7:0] b, input logic es, input logic er);
      uefc_remote_inst.send_char(b);
      #1;
      chk_bit(rx_fifo_wr, 1'b1);
      chk_byte(rx_fifo_data, b);
      chk_bit(stop_seen, es);
      chk_bit(resume_seen, er);
   endtask : rx_chk

   task automatic tally_and_finish;
      if (err_total == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish

   // ****************************************************************
   // Clock, watchdog and tests
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Whole run is under two hundred cycles; this limit is generous
   initial begin
      #100us;
      err_total++;
      $display("[FAIL] %0t watchdog expired", $time);
      tally_and_finish;
   end

   initial begin
      logic [7:0] cur;
      cur = 8'hff;
      err_total = 0;
      checks_done = 0;
      rst = 1'b1;
      {addr, wdata, wr, rd} = '0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk_bit(irq, 1'b0);
      chk_bit(rts_level, 1'b0);
      rd_chk(ADDR_ENH_CTRL, RST_BYTE);
      tick;
      chk_byte(rdata, 8'h00);
      for (int i = 0; i < 3; i++) begin
         rd_chk(LOCK[i][15:8], RST_BYTE);
      end
      rd_chk(8'h0d, 8'h00);
      // Guarded bits refuse writes while locked, keep what was latched
      for (int i = 0; i < 3; i++) begin
         wr_reg(ADDR_ENH_CTRL, 8'h00);
         wr_reg(LOCK[i][15:8], 8'hff);
         rd_chk(LOCK[i][15:8], ~LOCK[i][7:0]);
         wr_reg(ADDR_ENH_CTRL, 8'h10);
         wr_reg(LOCK[i][15:8], 8'hff);
         rd_chk(LOCK[i][15:8], 8'hff);
         wr_reg(ADDR_ENH_CTRL, 8'h00);
         wr_reg(LOCK[i][15:8], 8'h00);
         rd_chk(LOCK[i][15:8], LOCK[i][7:0]);
      end
      chk_byte(modem_control, PROT_MODEM_CTRL);
      chk_byte(interrupt_enable, PROT_INT_ENABLE);
      chk_byte(fifo_control, PROT_FIFO_CTRL);
      chk_byte(enhanced_feature_control, 8'h00);
      // Flow characters are sent both as control and, where the selects ignore them, as payload
      wr_reg(ADDR_RESUME_1, 8'h11);
      wr_reg(ADDR_RESUME_2, 8'h21);
      wr_reg(ADDR_STOP_1, 8'h13);
      wr_reg(ADDR_STOP_2, 8'h23);
      for (int i = 0; i < 15; i++) begin
         if (FLOW[i][17:10] !== cur) begin
            wr_reg(ADDR_ENH_CTRL, FLOW[i][17:10]);
            cur = FLOW[i][17:10];
         end
         rx_chk(FLOW[i][9:2], FLOW[i][1], FLOW[i][0]);
      end
      // Special character: selects cleared first, bit order checked
      wr_reg(ADDR_ENH_CTRL, 8'h00);
      wr_reg(ADDR_ENH_CTRL, 8'h30);
      wr_reg(ADDR_INT_STATUS, 8'hff);
      wr_reg(ADDR_STOP_2, 8'h01);
      wr_reg(ADDR_INT_MASK, 8'h10);
      rx_chk(8'h80, 1'b0, 1'b0);
      chk_bit(irq, 1'b0);
      rx_chk(8'h01, 1'b0, 1'b0);
      chk_bit(irq, 1'b1);
      rd_chk(ADDR_INT_STATUS, 8'h10);
      wr_reg(ADDR_ENH_CTRL, 8'h20);
      wr_reg(ADDR_INT_STATUS, 8'h10);
      rd_chk(ADDR_INT_STATUS, 8'h10);
      wr_reg(ADDR_ENH_CTRL, 8'h30);
      wr_reg(ADDR_INT_STATUS, 8'h10);
      tick;
      chk_bit(irq, 1'b0);
      wr_reg(ADDR_INT_MASK, 8'h00);
      rx_chk(8'h01, 1'b0, 1'b0);
      chk_bit(irq, 1'b0);
      rd_chk(ADDR_INT_STATUS, 8'h10);
      wr_reg(ADDR_INT_STATUS, 8'h10);
      wr_reg(ADDR_ENH_CTRL, 8'h10);
      rx_chk(8'h01, 1'b0, 1'b0);
      rd_chk(ADDR_INT_STATUS, 8'h00);
      // Manual request-to-send, then automatic with both level bounds
      wr_reg(ADDR_MODEM_CTRL, 8'h02);
      tick;
      chk_bit(rts_level, 1'b1);
      rd_chk(ADDR_LINE_STATE, 8'h01);
      wr_reg(ADDR_MODEM_CTRL, 8'h00);
      wr_reg(ADDR_FLOW_HIGH, 8'h04);
      wr_reg(ADDR_FLOW_LOW, 8'h02);
      uefc_remote_inst.set_level(8'h10);
      tick;
      tick;
      chk_bit(rts_level, 1'b0);
      uefc_remote_inst.set_level(8'h03);
      wr_reg(ADDR_ENH_CTRL, 8'h50);
      tick;
      chk_bit(rts_level, 1'b0);
      uefc_remote_inst.set_level(8'h04);
      tick;
      chk_bit(rts_level, 1'b1);
      uefc_remote_inst.set_level(8'h02);
      tick;
      chk_bit(rts_level, 1'b1);
      uefc_remote_inst.set_level(8'h01);
      tick;
      chk_bit(rts_level, 1'b0);
      tally_and_finish;
   end
endmodule : uefc_core_test
`default_nettype wire
